// *** include/fpis_consts.svh ***
// offsets, field positions, reset values and codes of the invalid-op unit
`ifndef FPIS_CONSTS_SVH
`define FPIS_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FPIS_OFF_STATUS 8'h00
`define FPIS_OFF_CTRL 8'h04
`define FPIS_OFF_TAGS 8'h08
`define FPIS_OFF_TOP 8'h0C
`define FPIS_OFF_IRQ_STAT 8'h10
`define FPIS_OFF_IRQ_MASK 8'h14
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FPIS_BIT_IE 0
`define FPIS_BIT_SF 6
`define FPIS_BIT_ES 7
`define FPIS_BIT_C1 9
`define FPIS_BIT_IM 0
`define FPIS_EV_STACK 0
`define FPIS_EV_OPND 1
`define FPIS_EV_HAND 2
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define FPIS_RST_CTRL 16'h0001
`define FPIS_RST_TAGS 16'hFFFF
`define FPIS_RST_TOP 3'h0
`define FPIS_TAG_VALID 2'h0
`define FPIS_TAG_SPECIAL 2'h2
`define FPIS_TAG_EMPTY 2'h3
`define FPIS_RESP_OKAY 2'h0
`define FPIS_RESP_SLVERR 2'h2
`define FPIS_NUM_REGS 8
`endif

// *** include/fpis_pkg.sv ***
// types shared by the invalid-op unit and its bench
package fpis_pkg;
	// instruction kinds seen by the unit
	typedef enum logic [3:0] {
		K_LD_EXT = 4'h0, // extended load from memory, push
		K_LD_SD = 4'h1, // single/double load, push
		K_LD_INT = 4'h2, // integer load, push
		K_LD_BCD = 4'h3, // decimal load, push
		K_LD_CONST = 4'h4, // constant load, push
		K_LD_REG = 4'h5, // register copy, push
		K_ST_EXT = 4'h6, // extended store to memory
		K_ST_SD = 4'h7, // single/double store
		K_ST_INT = 4'h8, // integer store
		K_ST_BCD = 4'h9, // decimal store
		K_MATH = 4'hA, // math on st0 and st(i)
		K_COMPARE = 4'hB, // compare st0 with st(i)
		K_SIGN = 4'hC, // absolute value, sign change
		K_XCHG = 4'hD, // exchange st0 and st(i)
		K_EXAMINE = 4'hE, // examine st0
		K_CONTROL = 4'hF // control, environment, no stack operand
	} fpis_kind_t;
	// form of the indefinite value
	typedef enum logic [1:0] {
		FORM_FLOAT = 2'h0,
		FORM_INT = 2'h1,
		FORM_BCD = 2'h2
	} fpis_form_t;
endpackage

// *** logic/fpis_invalid_op_unit.sv ***
// invalid-operation and register-stack fault unit with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "fpis_consts.svh"
module fpis_invalid_op_unit (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// instruction from the pipeline
	input wire logic op_valid,
	input wire fpis_pkg::fpis_kind_t op_kind,
	input wire logic [2:0] op_sti,
	input wire logic op_pop,
	input wire logic op_operand_invalid,
	// outcome of each instruction
	output logic res_valid,
	output logic res_stack_fault,
	output logic res_invalid_operand,
	output logic res_indef_write,
	output fpis_pkg::fpis_form_t res_indef_form,
	output logic res_handler_req,
	output logic [2:0] stack_top,
	output logic irq
);
	import fpis_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic ie_q, sf_q, es_q, c1_q; // status word flags
	logic [15:0] ctrl_q; // control word
	logic [15:0] tags_q; // two tag bits per entry
	logic [2:0] top_q; // stack-top pointer
	logic [2:0] ev_q, mask_q; // interrupt status and mask
	logic irq_q;
	logic res_v_q, res_sf_q, res_ia_q, res_ind_q, res_h_q;
	fpis_form_t res_form_q;
	logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, bresp_err_q;
	logic arready_q, rvalid_q, rresp_err_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;

	// ----------------------------------------------------------------
	// instruction classification
	// ----------------------------------------------------------------
	wire logic is_push = op_kind inside {K_LD_EXT, K_LD_SD, K_LD_INT,
		K_LD_BCD, K_LD_CONST, K_LD_REG};
	wire logic is_store = op_kind inside {K_ST_EXT, K_ST_SD, K_ST_INT,
		K_ST_BCD};
	// arithmetic kinds only; moves, ext loads/stores, sign ops are not
	wire logic is_arith = op_kind inside {K_LD_SD, K_LD_INT, K_LD_BCD,
		K_ST_SD, K_ST_INT, K_ST_BCD, K_MATH, K_COMPARE};
	wire logic uses_st0 = is_store || op_kind inside {K_MATH, K_COMPARE,
		K_SIGN, K_XCHG};
	wire logic uses_sti = op_kind inside {K_LD_REG, K_MATH, K_COMPARE,
		K_XCHG};

	// ----------------------------------------------------------------
	// tag checks
	// ----------------------------------------------------------------
	wire logic [2:0] idx_b = top_q + op_sti; // st(i), wraps mod 8
	wire logic [2:0] idx_push = top_q - 3'h1; // slot below top
	wire logic [1:0] tag_a = tags_q[{top_q, 1'b0} +: 2];
	wire logic [1:0] tag_b = tags_q[{idx_b, 1'b0} +: 2];
	wire logic [1:0] tag_p = tags_q[{idx_push, 1'b0} +: 2];
	// sources are looked at before anything commits
	wire logic underflow = op_valid && ((uses_st0 &&
		tag_a == `FPIS_TAG_EMPTY) || (uses_sti &&
		tag_b == `FPIS_TAG_EMPTY));
	// any tag but empty counts as occupied
	wire logic overflow = op_valid && is_push && !underflow &&
		tag_p != `FPIS_TAG_EMPTY;
	wire logic stack_fault = underflow || overflow;
	// operand faults from non-arithmetic kinds are dropped
	wire logic opnd_fault = op_valid && is_arith && op_operand_invalid &&
		!stack_fault;
	wire logic invalid = stack_fault || opnd_fault;
	wire logic masked = ctrl_q[`FPIS_BIT_IM];
	wire logic handler = invalid && !masked;
	wire logic has_dest = is_push || is_store || op_kind inside {K_MATH,
		K_SIGN, K_XCHG};
	wire logic indef = invalid && masked && has_dest;
	wire fpis_form_t form = (op_kind == K_ST_INT) ? FORM_INT :
		(op_kind == K_ST_BCD) ? FORM_BCD : FORM_FLOAT;
	wire logic commit = op_valid && !handler;

	// ----------------------------------------------------------------
	// stack update ports
	// ----------------------------------------------------------------
	wire logic do_pop = commit && op_pop && !is_push;
	// port a: st0 emptied by a pop or refilled by an exchange
	wire logic a_en = do_pop || (commit && op_kind == K_XCHG);
	wire logic [1:0] a_val = (op_kind == K_XCHG) ?
		((tag_b == `FPIS_TAG_EMPTY) ? `FPIS_TAG_SPECIAL : tag_b) :
		`FPIS_TAG_EMPTY;
	// port b: result register
	wire logic b_en = commit && (is_push || op_kind inside {K_MATH,
		K_XCHG} || (op_kind == K_SIGN && indef));
	wire logic [2:0] b_idx = is_push ? idx_push :
		(op_kind == K_XCHG || (op_kind == K_MATH && op_pop)) ?
		idx_b : top_q;
	wire logic [1:0] b_val = (op_kind == K_XCHG) ?
		((tag_a == `FPIS_TAG_EMPTY) ? `FPIS_TAG_SPECIAL : tag_a) :
		indef ? `FPIS_TAG_SPECIAL : `FPIS_TAG_VALID;
	// eight slots, pointer arithmetic wraps at the ends
	wire logic [2:0] top_d = (commit && is_push) ? idx_push :
		do_pop ? top_q + 3'h1 : top_q;

	// ----------------------------------------------------------------
	// register access decode
	// ----------------------------------------------------------------
	wire logic do_write = aw_held_q && w_held_q && !bvalid_q;
	wire logic do_read = s_axi_arvalid && arready_q;
	wire logic [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire logic wr_ok = awaddr_q[7:5] == 3'h0 && awaddr_q[1:0] == 2'h0 &&
		awaddr_q[4:2] <= 3'h5;
	wire logic wr_stat = do_write && awaddr_q == `FPIS_OFF_STATUS;
	wire logic wr_ctrl = do_write && awaddr_q == `FPIS_OFF_CTRL;
	wire logic wr_tags = do_write && awaddr_q == `FPIS_OFF_TAGS;
	wire logic wr_top = do_write && awaddr_q == `FPIS_OFF_TOP &&
		wstrb_q[0];
	wire logic wr_evst = do_write && awaddr_q == `FPIS_OFF_IRQ_STAT &&
		wstrb_q[0];
	wire logic wr_mask = do_write && awaddr_q == `FPIS_OFF_IRQ_MASK &&
		wstrb_q[0];
	wire logic [15:0] wd = wdata_q[15:0] & wmask;
	wire logic [15:0] stat_word = {6'h00, c1_q, 1'b0, es_q, sf_q,
		5'h00, ie_q};
	wire logic [15:0] stat_wr = (stat_word & ~wmask) | wd;
	wire logic [15:0] tags_sw = (tags_q & ~wmask) | wd;
	wire logic rd_ok = s_axi_araddr[7:5] == 3'h0 &&
		s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[4:2] <= 3'h5;
	wire logic [15:0] rd_val =
		(s_axi_araddr == `FPIS_OFF_STATUS) ? stat_word :
		(s_axi_araddr == `FPIS_OFF_CTRL) ? ctrl_q :
		(s_axi_araddr == `FPIS_OFF_TAGS) ? tags_q :
		(s_axi_araddr == `FPIS_OFF_TOP) ? {13'h0000, top_q} :
		(s_axi_araddr == `FPIS_OFF_IRQ_STAT) ? {13'h0000, ev_q} :
		(s_axi_araddr == `FPIS_OFF_IRQ_MASK) ? {13'h0000, mask_q} :
		16'h0000;

	// ----------------------------------------------------------------
	// status flag next values, hardware set wins over software
	// ----------------------------------------------------------------
	wire logic ie_d = invalid || (wr_stat ? stat_wr[`FPIS_BIT_IE] : ie_q);
	// only a stack fault touches sf; operand faults leave it
	wire logic sf_d = stack_fault ||
		(wr_stat ? stat_wr[`FPIS_BIT_SF] : sf_q);
	wire logic c1_d = stack_fault ? overflow :
		(wr_stat ? stat_wr[`FPIS_BIT_C1] : c1_q);
	wire logic [15:0] ctrl_d = wr_ctrl ? ((ctrl_q & ~wmask) | wd) : ctrl_q;
	wire logic [2:0] ev_set = {handler, opnd_fault, stack_fault};
	wire logic [2:0] ev_d = ev_set |
		(ev_q & ~(wr_evst ? wdata_q[2:0] : 3'h0));

	// ----------------------------------------------------------------
	// per-entry tag update
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `FPIS_NUM_REGS; gi++) begin : g_tag
			wire logic [2:0] me = 3'(gi);
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					tags_q[2*gi +: 2] <= 2'h3;
				end else if (a_en && top_q == me) begin
					tags_q[2*gi +: 2] <= a_val;
				end else if (b_en && b_idx == me) begin
					tags_q[2*gi +: 2] <= b_val;
				end else if (wr_tags) begin
					tags_q[2*gi +: 2] <= tags_sw[2*gi +: 2];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// status, control, stack pointer and interrupt registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ie_q <= 1'b0;
			sf_q <= 1'b0;
			c1_q <= 1'b0;
			es_q <= 1'b0;
			ctrl_q <= `FPIS_RST_CTRL;
			top_q <= `FPIS_RST_TOP;
			ev_q <= 3'h0;
			mask_q <= 3'h0;
			irq_q <= 1'b0;
		end else begin
			ie_q <= ie_d;
			sf_q <= sf_d;
			c1_q <= c1_d;
			// summary follows the pending invalid flag while IM is clear
			es_q <= ie_d && !ctrl_d[`FPIS_BIT_IM];
			ctrl_q <= ctrl_d;
			// any committed instruction beats software write, even one that leaves the pointer
			top_q <= (commit || !wr_top) ? top_d : wdata_q[2:0];
			ev_q <= ev_d;
			mask_q <= wr_mask ? wdata_q[2:0] : mask_q;
			irq_q <= |(ev_d & (wr_mask ? wdata_q[2:0] : mask_q));
		end
	end

	// ----------------------------------------------------------------
	// per-instruction outcome pulses
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_v_q <= 1'b0;
			res_sf_q <= 1'b0;
			res_ia_q <= 1'b0;
			res_ind_q <= 1'b0;
			res_h_q <= 1'b0;
			res_form_q <= FORM_FLOAT;
		end else begin
			res_v_q <= op_valid;
			res_sf_q <= stack_fault;
			res_ia_q <= opnd_fault;
			res_ind_q <= indef;
			res_h_q <= handler;
			res_form_q <= form;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	wire logic aw_take = s_axi_awvalid && awready_q;
	wire logic w_take = s_axi_wvalid && wready_q;
	wire logic aw_held_d = aw_held_q ? !do_write : aw_take;
	wire logic w_held_d = w_held_q ? !do_write : w_take;
	wire logic bvalid_d = do_write || (bvalid_q && !s_axi_bready);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_err_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= !aw_held_d && !bvalid_d;
			wready_q <= !w_held_d && !bvalid_d;
			bvalid_q <= bvalid_d;
			bresp_err_q <= do_write ? !wr_ok : bresp_err_q;
			awaddr_q <= aw_take ? s_axi_awaddr : awaddr_q;
			wdata_q <= w_take ? s_axi_wdata : wdata_q;
			wstrb_q <= w_take ? s_axi_wstrb : wstrb_q;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_err_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else if (do_read) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_err_q <= !rd_ok;
			rdata_q <= {16'h0000, rd_val};
		end else begin
			arready_q <= !rvalid_q || s_axi_rready;
			rvalid_q <= rvalid_q && !s_axi_rready;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_err_q ? `FPIS_RESP_SLVERR : `FPIS_RESP_OKAY;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_err_q ? `FPIS_RESP_SLVERR : `FPIS_RESP_OKAY;
	assign res_valid = res_v_q;
	assign res_stack_fault = res_sf_q;
	assign res_invalid_operand = res_ia_q;
	assign res_indef_write = res_ind_q;
	assign res_indef_form = res_form_q;
	assign res_handler_req = res_h_q;
	assign stack_top = top_q;
	assign irq = irq_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_nonarith_no_opnd: assert property (op_valid && !is_arith |=>
		!res_invalid_operand) else $error("operand fault on non-arith");
	a_fault_sets_flags: assert property (stack_fault |=>
		ie_q && sf_q && res_stack_fault) else $error("flags not set");
	a_c1_direction: assert property (stack_fault |=>
		c1_q == $past(overflow)) else $error("c1 wrong");
	a_opnd_keeps_sf: assert property (opnd_fault && sf_q |=>
		sf_q) else $error("sf cleared");
	a_push_full: assert property (op_valid && is_push &&
		!underflow && tag_p != `FPIS_TAG_EMPTY |=>
		res_stack_fault && c1_q) else $error("overflow missed");
	a_empty_source: assert property (op_valid && uses_st0 &&
		tag_a == `FPIS_TAG_EMPTY |=> res_stack_fault && !c1_q)
		else $error("underflow missed");
	a_top_wraps: assert property (commit && is_push &&
		top_q == 3'h0 |=> top_q == 3'h7) else $error("no wrap");
	a_unmasked_hold: assert property (handler |=>
		$stable(top_q) && $stable(tags_q) && res_handler_req &&
		!res_indef_write) else $error("state moved on handler");
	a_masked_indef: assert property (invalid && masked &&
		has_dest |=> res_indef_write && !res_handler_req)
		else $error("indefinite missing");
	a_summary_set: assert property (handler |=> es_q)
		else $error("summary not set");
	a_irq_level: assert property (irq_q |-> |(ev_q & mask_q))
		else $error("irq without cause");

	c_overflow_masked: cover property (overflow && masked);
	c_underflow_handler: cover property (underflow && !masked);
	c_opnd_after_sf: cover property (opnd_fault && sf_q);
endmodule
`default_nettype wire

// *** tb/fpis_pipe_model.sv ***
// pipeline model: issues one instruction and captures its outcome
`timescale 1ns/1ps
`default_nettype none
module fpis_pipe_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request from the bench
	input wire logic issue,
	input wire logic [3:0] i_kind,
	input wire logic [2:0] i_sti,
	input wire logic i_pop,
	input wire logic i_inv,
	// instruction towards the unit
	output logic op_valid,
	output fpis_pkg::fpis_kind_t op_kind,
	output logic [2:0] op_sti,
	output logic op_pop,
	output logic op_operand_invalid,
	// outcome from the unit
	input wire logic res_valid,
	input wire logic [3:0] res_bits,
	input wire logic [1:0] res_form,
	// captured outcome
	output logic done,
	output logic [3:0] cap_bits,
	output logic [1:0] cap_form
);
	import fpis_pkg::*;
	// one-cycle pulse; idle payload inverted each cycle, so stale values match only every second cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_valid <= 1'b0;
			op_kind <= K_CONTROL;
			{op_sti, op_pop, op_operand_invalid} <= 5'h00;
		end else if (issue) begin
			op_valid <= 1'b1;
			op_kind <= fpis_kind_t'(i_kind);
			{op_sti, op_pop, op_operand_invalid} <= {i_sti, i_pop, i_inv};
		end else begin
			op_valid <= 1'b0;
			op_kind <= fpis_kind_t'(~op_kind);
			{op_sti, op_pop, op_operand_invalid} <=
				~{op_sti, op_pop, op_operand_invalid};
		end
	end
	// outcome stands one cycle, so take it in that cycle
	always_ff @(posedge aclk) begin
		done <= aresetn && res_valid;
		if (res_valid) begin
			cap_bits <= res_bits;
			cap_form <= res_form;
		end
	end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the invalid-operation unit
`timescale 1ns/1ps
`default_nettype none
`include "fpis_consts.svh"
module tb;
	import fpis_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, res_valid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, cap_form;
	logic issue, i_pop, i_inv, done, op_valid, op_pop, op_inv;
	logic r_sf, r_inv, r_ind, r_hnd;
	logic [3:0] i_kind, cap_bits;
	logic [2:0] i_sti, op_sti, stack_top, et;
	fpis_kind_t op_kind;
	fpis_form_t res_form;
	int fail_count = 0;
	int cmp_count = 0;
	logic [3:0] ukind [4] = '{K_ST_SD, K_ST_INT, K_ST_BCD, K_ST_EXT};
	logic [1:0] uform [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
	// ----------------------------------------------------------------
	// design and pipeline model
	// ----------------------------------------------------------------
	fpis_invalid_op_unit fpis_invalid_op_unit_i (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .op_valid(op_valid), .op_kind(op_kind),
		.op_sti(op_sti), .op_pop(op_pop), .op_operand_invalid(op_inv),
		.res_valid(res_valid), .res_stack_fault(r_sf),
		.res_invalid_operand(r_inv), .res_indef_write(r_ind),
		.res_indef_form(res_form), .res_handler_req(r_hnd),
		.stack_top(stack_top), .irq(irq));
	fpis_pipe_model fpis_pipe_model_i (.aclk(aclk), .aresetn(aresetn),
		.issue(issue), .i_kind(i_kind), .i_sti(i_sti), .i_pop(i_pop),
		.i_inv(i_inv), .op_valid(op_valid), .op_kind(op_kind),
		.op_sti(op_sti), .op_pop(op_pop), .op_operand_invalid(op_inv),
		.res_valid(res_valid), .res_bits({r_sf, r_inv, r_ind, r_hnd}),
		.res_form(res_form), .done(done), .cap_bits(cap_bits),
		.cap_form(cap_form));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// count and report one comparison
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// axi write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask
	// axi read, data taken at the rvalid edge
	task automatic rdx(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] v);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 100);
		rready <= 1'b0;
		v = rdata;
		chk("rresp", er, rresp);
	endtask
	// read a register and compare it
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] v;
		rdx(a, `FPIS_RESP_OKAY, v);
		chk(nm, e, v);
	endtask
	// one instruction through the model, wait for its outcome
	task automatic run_op(input logic [3:0] k, input logic [2:0] s,
		input logic p, input logic v);
		int n;
		n = 0;
		@(posedge aclk);
		issue <= 1'b1;
		{i_kind, i_sti, i_pop, i_inv} <= {k, s, p, v};
		@(posedge aclk);
		issue <= 1'b0;
		do begin
			@(posedge aclk);
			#1;
			n++;
		end while (!done && n < 20);
		chk("done", 1, done);
	endtask
	// print counts and verdict, then stop
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		give_verdict();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{issue, i_kind, i_sti, i_pop, i_inv} = 10'h000;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values
		rchk("control", `FPIS_OFF_CTRL, 32'h1);
		rchk("tags", `FPIS_OFF_TAGS, 32'hFFFF);
		rchk("status", `FPIS_OFF_STATUS, 32'h0);
		chk("irq", 0, irq);
		$display("test reset done");
		// stores from an empty stack, masked
		for (int j = 0; j < 4; j++) begin
			run_op(ukind[j], 3'h0, 1'b0, 1'b0);
			chk("underflow bits", 32'hA, cap_bits);
			chk("form", uform[j], cap_form);
		end
		rchk("status", `FPIS_OFF_STATUS, 32'h41);
		rchk("top", `FPIS_OFF_TOP, 32'h0);
		$display("test underflow done");
		// eight pushes fill the stack, the ninth wraps onto a full entry
		wr(`FPIS_OFF_STATUS, 32'h0, `FPIS_RESP_OKAY);
		et = 3'h0;
		for (int j = 0; j < 8; j++) begin
			run_op(K_LD_EXT, 3'h0, 1'b0, 1'b0);
			et = et - 3'h1;
			chk("push bits", 32'h0, cap_bits);
			chk("top", et, stack_top);
		end
		rchk("tags", `FPIS_OFF_TAGS, 32'h0);
		run_op(K_LD_CONST, 3'h0, 1'b0, 1'b0);
		chk("overflow bits", 32'hA, cap_bits);
		chk("top", 32'h7, stack_top);
		rchk("status", `FPIS_OFF_STATUS, 32'h241);
		rchk("tags", `FPIS_OFF_TAGS, 32'h8000);
		$display("test overflow done");
		// operand faults on a full stack, every non-push kind
		for (int k = 6; k < 16; k++) begin
			run_op(k[3:0], 3'h1, 1'b0, 1'b1);
			chk("class", (k >= 7 && k <= 11), cap_bits[3:2]);
		end
		rdx(`FPIS_OFF_STATUS, `FPIS_RESP_OKAY, rd);
		chk("sticky flags", 32'h41, rd & 32'h41);
		$display("test classes done");
		// unmasked overflow goes to the handler and raises irq
		wr(`FPIS_OFF_IRQ_STAT, 32'h7, `FPIS_RESP_OKAY);
		rchk("irq status", `FPIS_OFF_IRQ_STAT, 32'h0);
		wr(`FPIS_OFF_IRQ_MASK, 32'h1, `FPIS_RESP_OKAY);
		wr(`FPIS_OFF_CTRL, 32'h0, `FPIS_RESP_OKAY);
		run_op(K_LD_EXT, 3'h0, 1'b0, 1'b0);
		chk("handler bits", 32'h9, cap_bits);
		chk("top", 32'h7, stack_top);
		// exchange in the class sweep swapped entries 7 and 0
		rchk("tags", `FPIS_OFF_TAGS, 32'h0002);
		rchk("status", `FPIS_OFF_STATUS, 32'h2C1);
		chk("irq", 1, irq);
		rchk("irq status", `FPIS_OFF_IRQ_STAT, 32'h5);
		wr(`FPIS_OFF_IRQ_STAT, 32'h1, `FPIS_RESP_OKAY);
		rchk("irq status", `FPIS_OFF_IRQ_STAT, 32'h4);
		chk("irq", 0, irq);
		$display("test unmasked done");
		// unmapped address answers with an error
		rdx(8'h18, `FPIS_RESP_SLVERR, rd);
		chk("unmapped data", 32'h0, rd);
		wr(8'h18, 32'hFFFF, `FPIS_RESP_SLVERR);
		$display("test unmapped done");
		give_verdict();
	end
endmodule
`default_nettype wire
